// [sar_adc_pkg.sv]
// shared constants, types and helpers for the converter control block
package sar_adc_pkg;

	localparam int ADDR_W = 32;
	localparam int DATA_W = 32;
	localparam int REG_W = 10;
	localparam int IRQ_W = 2;

	localparam logic [31:0] ADDR_STATUS = 32'h4004_8000;
	localparam logic [31:0] ADDR_SELECT = 32'h4004_8004;
	localparam logic [31:0] ADDR_CONTROL = 32'h4004_8008;
	localparam logic [31:0] ADDR_IRQ_STATUS = 32'h4004_800C;
	localparam logic [31:0] ADDR_IRQ_MASK = 32'h4004_8010;
	localparam logic [31:0] ADDR_RESULT = 32'h4004_8048;

	localparam logic [31:0] STATUS_RESET_VAL = 32'h0000_0080;
	localparam logic [9:0] SELECT_RESET_VAL = 10'h004;
	localparam logic [9:0] CONTROL_RESET_VAL = 10'h000;
	localparam logic [9:0] RESULT_RESET_VAL = 10'h000;

	localparam int STATUS_PHASE_LSB = 4;
	localparam int SEL_INT_MSB = 3;
	localparam int SEL_CH_LSB = 4;
	localparam int SEL_CH_MSB = 5;
	localparam int SEL_REFP_LSB = 6;
	localparam int SEL_REFP_MSB = 7;
	localparam int SEL_REFN_LSB = 8;
	localparam int SEL_REFN_MSB = 9;
	localparam int CTL_BIT0 = 0;
	localparam int CTL_STROBE = 1;
	localparam int CTL_POWER = 2;
	localparam int CTL_INT_LSB = 3;
	localparam int CTL_INT_MSB = 6;
	localparam int CTL_RES_LSB = 7;
	localparam int CTL_RES_MSB = 9;

	localparam int IRQ_DONE = 0;
	localparam int IRQ_REFUSED = 1;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	localparam logic [2:0] PH_STOP = 3'h0;
	localparam logic [2:0] PH_RISE = 3'h1;
	localparam logic [2:0] PH_SAMPLE = 3'h2;
	localparam logic [2:0] PH_CONVERT = 3'h3;
	localparam logic [2:0] PH_READY = 3'h4;

	localparam logic [3:0] FULL_BITS = 4'hA;
	localparam logic [3:0] CONV_EXTRA = 4'h1;
	localparam logic [9:0] RESULT_ALL = 10'h3FF;

	typedef enum logic [4:0]
	{
		S_STOP = 5'h01,
		S_RISE = 5'h02,
		S_SAMPLE = 5'h04,
		S_CONV = 5'h08,
		S_READY = 5'h10
	} seq_state_t;

	typedef struct packed
	{
		logic power;
		logic reset;
		logic [1:0] channel;
		logic [1:0] ref_pos;
		logic [1:0] ref_neg;
		logic [3:0] sel_internal;
		logic [3:0] ctl_internal;
		logic ctl_bit0;
		logic sample;
		logic convert;
		logic [2:0] res_code;
	} conv_ctrl_t;

	// number of result bits delivered for a resolution code
	function automatic logic [3:0] result_bits(input logic [2:0] code);
		result_bits = FULL_BITS - {1'b0, code};
	endfunction : result_bits

	// msb-aligned mask: dropped low bits read as zero
	function automatic logic [9:0] result_mask(input logic [2:0] code);
		result_mask = RESULT_ALL << code;
	endfunction : result_mask

endpackage : sar_adc_pkg

// [conv_sequencer.sv]
// conversion phase sequencer paced by the real-time clock tick
`timescale 1ns/10ps
module conv_sequencer
	import sar_adc_pkg::*;
#(
	parameter logic [3:0] RISE_TICKS = 4'h2,
	parameter logic [3:0] SAMPLE_TICKS = 4'h2
)
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic start,
	input wire logic powered,
	input wire logic rtc_tick,
	input wire logic core_ready,
	input wire logic [2:0] res_code,
	output logic [2:0] phase,
	output logic in_sample,
	output logic in_convert,
	output logic started,
	output logic done
);

	seq_state_t state_reg, state_next;
	logic [3:0] cnt_reg, cnt_next;
	logic [3:0] conv_ticks;
	logic [3:0] seen_reg, seen_next;

	always_comb
	begin
		conv_ticks = result_bits(res_code) + CONV_EXTRA;
		state_next = state_reg;
		cnt_next = cnt_reg;
		started = 1'b0;
		done = 1'b0;
		case (state_reg)
			S_STOP:
			begin
				cnt_next = '0;
				if (start && powered)
				begin
					started = 1'b1;
					state_next = S_RISE;
				end
			end
			S_RISE:
			begin
				if (rtc_tick)
				begin
					cnt_next = cnt_reg + 4'h1;
					if (cnt_reg + 4'h1 >= RISE_TICKS)
					begin
						cnt_next = '0;
						state_next = S_SAMPLE;
					end
				end
			end
			S_SAMPLE:
			begin
				if (rtc_tick)
				begin
					cnt_next = cnt_reg + 4'h1;
					if (cnt_reg + 4'h1 >= SAMPLE_TICKS)
					begin
						cnt_next = '0;
						state_next = S_CONV;
					end
				end
			end
			S_CONV:
			begin
				if (rtc_tick)
				begin
					cnt_next = cnt_reg + 4'h1;
					if (cnt_reg + 4'h1 >= conv_ticks)
					begin
						cnt_next = '0;
						state_next = S_READY;
					end
				end
			end
			S_READY:
			begin
				if (core_ready)
				begin
					done = 1'b1;
					state_next = S_STOP;
				end
			end
			default:
			begin
				state_next = S_STOP;
				cnt_next = '0;
			end
		endcase
		if (!powered)
		begin
			state_next = S_STOP;
			cnt_next = '0;
		end
		seen_next = (state_reg == S_CONV) ? seen_reg + {3'h0, rtc_tick} : '0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_reg <= S_STOP;
			cnt_reg <= '0;
			seen_reg <= '0;
		end
		else
		begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			seen_reg <= seen_next;
		end
	end

	always_comb
	begin
		case (state_reg)
			S_RISE: phase = PH_RISE;
			S_SAMPLE: phase = PH_SAMPLE;
			S_CONV: phase = PH_CONVERT;
			S_READY: phase = PH_READY;
			default: phase = PH_STOP;
		endcase
		in_sample = (state_reg == S_SAMPLE);
		in_convert = (state_reg == S_CONV);
	end

	conv_length_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(state_reg == S_CONV && state_next == S_READY)
		|-> (seen_reg + 4'h1 == result_bits(res_code) + 4'h1))
		else $error("conversion tick count wrong for resolution");

	phase_order_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(state_reg == S_RISE && powered) |=> (state_reg inside {S_RISE, S_SAMPLE}))
		else $error("rise delay not followed by sample phase");

endmodule : conv_sequencer

// [irq_block.sv]
// sticky event flags with mask, write one to clear
`timescale 1ns/10ps
module irq_block
#(
	parameter int W = 2
)
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [W-1:0] event_in,
	input wire logic clr_we,
	input wire logic [W-1:0] clr_bits,
	input wire logic mask_we,
	input wire logic [W-1:0] mask_bits,
	output logic [W-1:0] status_reg,
	output logic [W-1:0] mask_reg,
	output logic irq_reg
);

	logic [W-1:0] status_next, mask_next;
	logic irq_next;

	always_comb
	begin
		// a new event beats a clear in the same cycle
		status_next = (status_reg & ~(clr_we ? clr_bits : '0)) | event_in;
		mask_next = mask_we ? mask_bits : mask_reg;
		irq_next = |(status_next & mask_next);
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			status_reg <= '0;
			mask_reg <= '0;
			irq_reg <= 1'b0;
		end
		else
		begin
			status_reg <= status_next;
			mask_reg <= mask_next;
			irq_reg <= irq_next;
		end
	end

	irq_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
		irq_reg == |(status_reg & mask_reg))
		else $error("interrupt output disagrees with status and mask");

endmodule : irq_block

// [sar_adc_control_regs.sv]
// register bank, bus slave and converter control for the sar converter
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/10ps
module sar_adc_control_regs
	import sar_adc_pkg::*;
#(
	parameter logic [3:0] RISE_TICKS = 4'h2,
	parameter logic [3:0] SAMPLE_TICKS = 4'h2
)
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic rtc_tick,
	input wire logic core_ready,
	input wire logic [REG_W-1:0] core_result,
	output conv_ctrl_t core_ctrl,
	output logic irq
);

	// write channel state
	logic aw_held_reg, aw_held_next;
	logic w_held_reg, w_held_next;
	logic [ADDR_W-1:0] awaddr_reg, awaddr_next;
	logic [DATA_W-1:0] wdata_reg, wdata_next;
	logic [3:0] wstrb_reg, wstrb_next;
	logic bvalid_reg, bvalid_next;
	logic [1:0] bresp_reg, bresp_next;
	logic do_write;

	// read channel state
	logic rvalid_reg, rvalid_next;
	logic [DATA_W-1:0] rdata_reg, rdata_next;
	logic [1:0] rresp_reg, rresp_next;

	// registers
	logic [REG_W-1:0] sel_reg, sel_next;
	logic [REG_W-1:0] ctl_reg, ctl_next;
	logic [REG_W-1:0] result_reg, result_next;
	conv_ctrl_t ctrl_reg, ctrl_next;

	logic wr_sel, wr_ctl, wr_irq_clr, wr_irq_mask;
	logic [2:0] phase;
	logic in_sample, in_convert, started, done;
	logic [IRQ_W-1:0] irq_status, irq_mask, irq_events;
	logic powered;
	// function results cannot be sliced in place, so the words stand alone
	logic [REG_W-1:0] clr_word, mask_word;

	// merge a bus write into a 10-bit register under byte strobes
	function automatic logic [REG_W-1:0] merge10(
		input logic [REG_W-1:0] old,
		input logic [DATA_W-1:0] data,
		input logic [3:0] strb);
		logic [REG_W-1:0] r;
		r = old;
		if (strb[0])
			r[7:0] = data[7:0];
		if (strb[1])
			r[9:8] = data[9:8];
		merge10 = r;
	endfunction : merge10

	function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
		is_mapped = (a == ADDR_STATUS) || (a == ADDR_SELECT)
			|| (a == ADDR_CONTROL) || (a == ADDR_RESULT)
			|| (a == ADDR_IRQ_STATUS) || (a == ADDR_IRQ_MASK);
	endfunction : is_mapped

	assign powered = ctl_reg[CTL_POWER];

	conv_sequencer #(
		.RISE_TICKS(RISE_TICKS),
		.SAMPLE_TICKS(SAMPLE_TICKS)
	) u_seq (
		.aclk(aclk),
		.aresetn(aresetn),
		.start(ctl_reg[CTL_STROBE]),
		.powered(powered),
		.rtc_tick(rtc_tick),
		.core_ready(core_ready),
		.res_code(ctl_reg[CTL_RES_MSB:CTL_RES_LSB]),
		.phase(phase),
		.in_sample(in_sample),
		.in_convert(in_convert),
		.started(started),
		.done(done)
	);

	assign irq_events[IRQ_DONE] = done;
	assign irq_events[IRQ_REFUSED] = ctl_reg[CTL_STROBE] && !powered;
	assign clr_word = merge10('0, wdata_reg, wstrb_reg);
	assign mask_word = merge10({{(REG_W-IRQ_W){1'b0}}, irq_mask}, wdata_reg,
		wstrb_reg);

	irq_block #(
		.W(IRQ_W)
	) u_irq (
		.aclk(aclk),
		.aresetn(aresetn),
		.event_in(irq_events),
		.clr_we(wr_irq_clr),
		.clr_bits(clr_word[IRQ_W-1:0]),
		.mask_we(wr_irq_mask),
		.mask_bits(mask_word[IRQ_W-1:0]),
		.status_reg(irq_status),
		.mask_reg(irq_mask),
		.irq_reg(irq)
	);

	// write address and data are taken independently, in either order
	always_comb
	begin
		do_write = aw_held_reg && w_held_reg && !bvalid_reg;
		aw_held_next = aw_held_reg;
		w_held_next = w_held_reg;
		awaddr_next = awaddr_reg;
		wdata_next = wdata_reg;
		wstrb_next = wstrb_reg;
		bvalid_next = bvalid_reg;
		bresp_next = bresp_reg;
		if (s_axi_awvalid && !aw_held_reg)
		begin
			aw_held_next = 1'b1;
			awaddr_next = s_axi_awaddr;
		end
		if (s_axi_wvalid && !w_held_reg)
		begin
			w_held_next = 1'b1;
			wdata_next = s_axi_wdata;
			wstrb_next = s_axi_wstrb;
		end
		if (bvalid_reg && s_axi_bready)
			bvalid_next = 1'b0;
		if (do_write)
		begin
			aw_held_next = 1'b0;
			w_held_next = 1'b0;
			bvalid_next = 1'b1;
			bresp_next = is_mapped(awaddr_reg) ? RESP_OKAY : RESP_DECERR;
		end
		wr_sel = do_write && (awaddr_reg == ADDR_SELECT);
		wr_ctl = do_write && (awaddr_reg == ADDR_CONTROL);
		wr_irq_clr = do_write && (awaddr_reg == ADDR_IRQ_STATUS);
		wr_irq_mask = do_write && (awaddr_reg == ADDR_IRQ_MASK);
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			awaddr_reg <= '0;
			wdata_reg <= '0;
			wstrb_reg <= '0;
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
		end
		else
		begin
			aw_held_reg <= aw_held_next;
			w_held_reg <= w_held_next;
			awaddr_reg <= awaddr_next;
			wdata_reg <= wdata_next;
			wstrb_reg <= wstrb_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
		end
	end

	// ready is simply "slot empty", so it comes straight from a flop
	assign s_axi_awready = !aw_held_reg;
	assign s_axi_wready = !w_held_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;

	// reads answer one cycle after the address is taken
	always_comb
	begin
		rvalid_next = rvalid_reg;
		rdata_next = rdata_reg;
		rresp_next = rresp_reg;
		if (rvalid_reg && s_axi_rready)
			rvalid_next = 1'b0;
		if (s_axi_arvalid && !rvalid_reg)
		begin
			rvalid_next = 1'b1;
			rresp_next = RESP_OKAY;
			rdata_next = '0;
			case (s_axi_araddr)
				ADDR_STATUS: rdata_next = STATUS_RESET_VAL
					| ({29'h0, phase} << STATUS_PHASE_LSB);
				ADDR_SELECT: rdata_next[REG_W-1:0] = sel_reg;
				ADDR_CONTROL: rdata_next[REG_W-1:0] = ctl_reg;
				ADDR_RESULT: rdata_next[REG_W-1:0] = result_reg;
				ADDR_IRQ_STATUS: rdata_next[IRQ_W-1:0] = irq_status;
				ADDR_IRQ_MASK: rdata_next[IRQ_W-1:0] = irq_mask;
				default: rresp_next = RESP_DECERR;
			endcase
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_reg <= 1'b0;
			rdata_reg <= '0;
			rresp_reg <= RESP_OKAY;
		end
		else
		begin
			rvalid_reg <= rvalid_next;
			rdata_reg <= rdata_next;
			rresp_reg <= rresp_next;
		end
	end

	assign s_axi_arready = !rvalid_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;

	// register bank and converter drive
	always_comb
	begin
		sel_next = wr_sel ? merge10(sel_reg, wdata_reg, wstrb_reg) : sel_reg;
		ctl_next = ctl_reg;
		// strobe clears itself once taken; a refused strobe is dropped too,
		// so it cannot fire later by surprise at power-up
		if (started || !powered)
			ctl_next[CTL_STROBE] = 1'b0;
		if (wr_ctl)
			ctl_next = merge10(ctl_reg, wdata_reg, wstrb_reg);
		result_next = result_reg;
		if (done)
			result_next = core_result
				& result_mask(ctl_reg[CTL_RES_MSB:CTL_RES_LSB]);
		ctrl_next.power = ctl_reg[CTL_POWER];
		ctrl_next.reset = ctl_reg[CTL_POWER] && (phase == PH_STOP);
		ctrl_next.channel = sel_reg[SEL_CH_MSB:SEL_CH_LSB];
		ctrl_next.ref_pos = sel_reg[SEL_REFP_MSB:SEL_REFP_LSB];
		ctrl_next.ref_neg = sel_reg[SEL_REFN_MSB:SEL_REFN_LSB];
		ctrl_next.sel_internal = sel_reg[SEL_INT_MSB:0];
		ctrl_next.ctl_internal = ctl_reg[CTL_INT_MSB:CTL_INT_LSB];
		ctrl_next.ctl_bit0 = ctl_reg[CTL_BIT0];
		ctrl_next.sample = in_sample;
		ctrl_next.convert = in_convert;
		ctrl_next.res_code = ctl_reg[CTL_RES_MSB:CTL_RES_LSB];
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sel_reg <= SELECT_RESET_VAL;
			ctl_reg <= CONTROL_RESET_VAL;
			result_reg <= RESULT_RESET_VAL;
			ctrl_reg <= '0;
		end
		else
		begin
			sel_reg <= sel_next;
			ctl_reg <= ctl_next;
			result_reg <= result_next;
			ctrl_reg <= ctrl_next;
		end
	end

	assign core_ctrl = ctrl_reg;

	strobe_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(started && !wr_ctl) |=> !ctl_reg[CTL_STROBE])
		else $error("start strobe not cleared after conversion began");

	no_start_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(!powered && $past(!powered)) |-> (phase == PH_STOP && !started))
		else $error("conversion launched while powered down");

	channel_route_a: assert property (@(posedge aclk) disable iff (!aresetn)
		##1 core_ctrl.channel == $past(sel_reg[SEL_CH_MSB:SEL_CH_LSB]))
		else $error("converter channel differs from select field");

	power_drive_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(!ctl_reg[CTL_POWER]) |=> (!core_ctrl.power && !core_ctrl.reset))
		else $error("converter powered while control bit is low");

	result_align_a: assert property (@(posedge aclk) disable iff (!aresetn)
		done |=> (result_reg == (($past(core_result)) & result_mask(
			$past(ctl_reg[CTL_RES_MSB:CTL_RES_LSB])))))
		else $error("result not captured msb aligned");

	status_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_STATUS)
		|=> (s_axi_rdata[6:4] == $past(phase)))
		else $error("status read does not show phase");

	done_irq_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(done && irq_mask[IRQ_DONE]) |=> irq)
		else $error("completed conversion raised no interrupt");

	result_hold_a: assert property (@(posedge aclk)
		disable iff (!aresetn)
		!done |=> (result_reg == $past(result_reg)))
		else $error("result changed without a completed conversion");

	stop_reset_a: assert property (@(posedge aclk)
		disable iff (!aresetn)
		(ctl_reg[CTL_POWER] && phase == PH_STOP) |=> core_ctrl.reset)
		else $error("powered converter not held in reset while stopped");

	refused_flag_a: assert property (@(posedge aclk)
		disable iff (!aresetn)
		(ctl_reg[CTL_STROBE] && !powered) |=> irq_status[IRQ_REFUSED])
		else $error("refused start left no flag");

endmodule : sar_adc_control_regs

// [conv_core_model.sv]
// behavioural analog converter core facing the control block
`timescale 1ns/10ps
module conv_core_model
	import sar_adc_pkg::*;
#(
	parameter int TICK_DIV = 5
)
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire conv_ctrl_t core_ctrl,
	input wire logic slow,
	input wire logic [9:0] value,
	output logic rtc_tick,
	output logic core_ready,
	output logic [9:0] core_result,
	output int conv_ticks
);
	int div;
	int wait_cnt;
	logic conv_d;
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			div <= 0;
			rtc_tick <= 1'b0;
			conv_d <= 1'b0;
			conv_ticks <= 0;
			wait_cnt <= 0;
			core_ready <= 1'b0;
			core_result <= 10'h000;
		end
		else
		begin
			div <= (div == TICK_DIV - 1) ? 0 : div + 1;
			rtc_tick <= (div == TICK_DIV - 1);
			conv_d <= core_ctrl.convert;
			if (core_ctrl.sample)
				conv_ticks <= 0;
			else if (core_ctrl.convert && rtc_tick)
				conv_ticks <= conv_ticks + 1;
			if (conv_d && !core_ctrl.convert)
				wait_cnt <= slow ? 20 : 8;
			else if (wait_cnt > 0)
				wait_cnt <= wait_cnt - 1;
			if (wait_cnt == 1)
				core_ready <= 1'b1;
			else if (core_ctrl.sample || !core_ctrl.power)
				core_ready <= 1'b0;
			// no result on offer: the last value toggles every cycle, never held steady
			if (wait_cnt == 1 || core_ready)
				core_result <= value;
			else
				core_result <= ~core_result;
		end
	end
endmodule : conv_core_model

// [tb_top.sv]
// self-checking bench for the converter control block
`timescale 1ns/10ps
module tb_top
	import sar_adc_pkg::*;
;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, rtc_tick, core_ready, irq;
	logic [3:0] wstrb = 4'hF;
	logic [1:0] bresp, rresp, resp;
	logic [9:0] core_result;
	logic [9:0] value = 10'h000;
	logic slow = 1'b0;
	conv_ctrl_t core_ctrl;
	int conv_ticks, failures = 0, n_compared = 0, cycles = 0;
	int seed = 32'h11BC0EAA;
	int code, ch;
	logic [31:0] d, sel_exp;
	int seq[$];

	always #5 aclk = ~aclk;

	sar_adc_control_regs u_dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .rtc_tick(rtc_tick),
		.core_ready(core_ready), .core_result(core_result),
		.core_ctrl(core_ctrl), .irq(irq));

	conv_core_model u_core (.aclk(aclk), .aresetn(aresetn),
		.core_ctrl(core_ctrl), .slow(slow), .value(value),
		.rtc_tick(rtc_tick), .core_ready(core_ready),
		.core_result(core_result), .conv_ticks(conv_ticks));

	task automatic give_verdict;
		$display("mismatches %0d of %0d compares", failures, n_compared);
		if (failures == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : give_verdict

	// a hung handshake would otherwise stall the run for ever
	always @(posedge aclk)
	begin
		cycles <= cycles + 1;
		if (cycles == 30000)
		begin
			failures = failures + 1;
			give_verdict();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp,
		input string what);
		n_compared = n_compared + 1;
		if (seen !== exp)
		begin
			failures = failures + 1;
			$display("BAD %0t %s seen %h want %h", $time, what, seen, exp);
		end
	endtask : check

	task automatic wr(input logic [31:0] a, input logic [31:0] v);
		logic aw_done;
		logic w_done;
		logic got;
		aw_done = 1'b0;
		w_done = 1'b0;
		got = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!got)
		begin
			@(posedge aclk);
			if (bvalid)
			begin
				got = 1'b1;
				resp = bresp;
				bready <= 1'b0;
			end
			if (!aw_done && awready)
			begin
				aw_done = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_done && wready)
			begin
				w_done = 1'b1;
				wvalid <= 1'b0;
			end
		end
	endtask : wr

	task automatic rd(input logic [31:0] a);
		logic got;
		got = 1'b0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!got)
		begin
			@(posedge aclk);
			if (rvalid)
			begin
				got = 1'b1;
				d = rdata;
				resp = rresp;
				rready <= 1'b0;
			end
			if (arvalid && arready)
				arvalid <= 1'b0;
		end
	endtask : rd

	initial
	begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		rd(ADDR_STATUS);
		check(d, 32'h80, "status reset");
		rd(ADDR_SELECT);
		check(d, 32'h4, "select reset");
		rd(ADDR_CONTROL);
		check(d, 32'h0, "control reset");
		rd(ADDR_RESULT);
		check(d, 32'h0, "result reset");
		rd(32'h4004_8020);
		check(d, 32'h0, "unmapped rd data");
		check(resp, RESP_DECERR, "unmapped rd");
		wr(32'h4004_8020, 32'h3FF);
		check(resp, RESP_DECERR, "unmapped wr");
		// only the phase field is hit: reserved bits never see a one
		wr(ADDR_STATUS, 32'h70);
		check(resp, RESP_OKAY, "status write ignored");
		rd(ADDR_STATUS);
		check(d, 32'h80, "status read only");
		wr(ADDR_IRQ_MASK, 32'h3);
		$display("bus and reset test done");
		for (code = 0; code < 8; code++)
		begin
			ch = {$random(seed)} % 3;
			value <= 10'($random(seed));
			slow <= code[0];
			sel_exp = {22'h0, 2'b10, 2'b10, ch[1:0], 4'h4};
			wr(ADDR_SELECT, sel_exp);
			rd(ADDR_SELECT);
			check(d, sel_exp, "select readback");
			check(core_ctrl.channel, ch[1:0], "input routed");
			// power up and start together; control bits 6:3 and 0 stay zero
			wr(ADDR_CONTROL, {22'h0, code[2:0], 7'h06});
			seq.delete();
			seq.push_back(0);
			repeat (300)
			begin
				rd(ADDR_STATUS);
				if (d[6:4] != seq[$])
					seq.push_back(d[6:4]);
				if (d[6:4] == 0 && seq.size() > 1)
					break;
			end
			check(seq.size(), 6, "phase count");
			foreach (seq[i])
				check(seq[i], (i == 5) ? 0 : i, "phase order");
			check(irq, 1'b1, "done irq");
			check(conv_ticks, 11 - code, "convert ticks");
			rd(ADDR_RESULT);
			check(d, {22'h0, value & (10'h3FF << code)}, "result");
			rd(ADDR_CONTROL);
			check(d, {22'h0, code[2:0], 7'h04}, "strobe self clear");
			check({core_ctrl.power, core_ctrl.reset}, 2'b11, "powered");
			check(core_ctrl.res_code, code[2:0], "res code");
			check({core_ctrl.ref_neg, core_ctrl.ref_pos, core_ctrl.channel,
				core_ctrl.sel_internal}, sel_exp, "select routed");
			check({core_ctrl.ctl_internal, core_ctrl.ctl_bit0}, 32'h0,
				"internal ctl");
			rd(ADDR_IRQ_STATUS);
			check(d, 32'h1, "done flag");
			wr(ADDR_IRQ_STATUS, 32'h1);
			check(irq, 1'b0, "irq cleared");
			$display("conversion test %0d done", code);
		end
		wr(ADDR_CONTROL, 32'h0);
		// the core drive lags the control register by one more edge
		@(posedge aclk);
		check(core_ctrl.power, 1'b0, "powered down");
		wr(ADDR_IRQ_MASK, 32'h1);
		wr(ADDR_CONTROL, 32'h2);
		repeat (4)
		begin
			rd(ADDR_STATUS);
			check(d, 32'h80, "no launch when off");
		end
		rd(ADDR_IRQ_STATUS);
		check(d, 32'h2, "refused flag");
		check(irq, 1'b0, "masked flag");
		wr(ADDR_IRQ_MASK, 32'h3);
		rd(ADDR_RESULT);
		check(irq, 1'b1, "unmasked flag");
		wr(ADDR_IRQ_STATUS, 32'h2);
		check(irq, 1'b0, "flag cleared");
		$display("power down test done");
		give_verdict();
	end
endmodule : tb_top
